// *** rtl/usbei_pkg.sv ***
package usbei_pkg;
    // Bus and register geometry
    localparam int EP_NUM = 3;
    localparam int DW = 32;
    localparam int AW = 12;
    localparam int RW = 8;
    localparam int IW = 10;
    // Register indexes; byte address is four times the index
    localparam logic [IW-1:0] IDX_IRQ_EN = 10'h0C2;
    localparam logic [IW-1:0] IDX_FIFO_RST = 10'h0D5;
    localparam logic [IW-1:0] IDX_IRQ_FLAGS = 10'h0F8;
    localparam logic [IW-1:0] IDX_EV_STAT = 10'h100;
    localparam logic [IW-1:0] IDX_EV_MASK = 10'h101;
    localparam logic [IW-1:0] IDX_EP_STAT = 10'h110;
    // Reset values
    localparam logic [RW-1:0] IRQ_EN_RST = 8'h00;
    localparam logic [RW-1:0] FIFO_RST_RST = 8'h00;
    localparam logic [RW-1:0] SRC_RST = 8'h00;
    // Source flag positions within an endpoint status register
    localparam int SRC_IN_DONE = 0;
    localparam int SRC_OUT_B0 = 1;
    localparam int SRC_SETUP = 2;
    localparam int SRC_STALL_CRC = 3;
    localparam int SRC_OUT_B1 = 6;
    localparam logic [RW-1:0] SRC_MASK = 8'h4F;
    localparam logic [RW-1:0] SRC_SETUP_ONLY = 8'h04;

    function automatic logic [AW-1:0] reg_addr(input logic [IW-1:0] idx);
        return {idx, 2'b00};
    endfunction : reg_addr
endpackage : usbei_pkg

// *** rtl/usbei_ep_if.sv ***
`timescale 1ns/10ps
// Per-endpoint link between the register front end and a source-flag holder
interface usbei_ep_if;
    logic [7:0] set;
    logic [7:0] keep;
    logic clr_stb;
    logic [7:0] flags;
    modport ctrl (output set, output keep, output clr_stb, input flags);
    modport src (input set, input keep, input clr_stb, output flags);
endinterface : usbei_ep_if

// *** rtl/usbei_ep_src.sv ***
`timescale 1ns/10ps
// Holds one endpoint's interrupt source flags
module usbei_ep_src (
    input wire logic pclk,
    input wire logic presetn,
    usbei_ep_if.src ep
);
    import usbei_pkg::*;

    logic [RW-1:0] flags_q, flags_d;

    // Firmware clears by writing zero; a hardware set wins over that clear
    always_comb begin
        flags_d = flags_q;
        if (ep.clr_stb) begin
            flags_d = flags_d & ep.keep;
        end
        if (ep.set[SRC_SETUP]) begin
            flags_d = SRC_SETUP_ONLY; // RULE8
        end else begin
            flags_d = (flags_d | ep.set) & SRC_MASK; // RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= SRC_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign ep.flags = flags_q;

    setup_clears_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        ep.set[SRC_SETUP] |=> ep.flags == SRC_SETUP_ONLY)
        else $error("setup did not clear other source flags");
    tx_done_sets_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        ep.set[SRC_IN_DONE] && !ep.set[SRC_SETUP] |=> ep.flags[SRC_IN_DONE])
        else $error("in packet done flag not set");
endmodule : usbei_ep_src

// *** rtl/usbei_irq_stat.sv ***
`timescale 1ns/10ps
// Sticky event status, read-to-clear, with mask and one level output
module usbei_irq_stat #(
    parameter int WIDTH = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] ev,
    input wire logic [WIDTH-1:0] rd_clr,
    input wire logic mask_we,
    input wire logic [WIDTH-1:0] mask_wdata,
    output logic [WIDTH-1:0] stat,
    output logic [WIDTH-1:0] mask,
    output logic irq
);
    logic [WIDTH-1:0] stat_q, stat_d, mask_q, mask_d;
    logic irq_q, irq_d;

    // Only bits seen by the read are cleared, and a new event wins
    always_comb begin
        stat_d = (stat_q & ~rd_clr) | ev;
        mask_d = mask_we ? mask_wdata : mask_q;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign stat = stat_q;
    assign mask = mask_q;
    assign irq = irq_q;

    ev_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|ev) |=> ((stat_q & $past(ev)) == $past(ev)))
        else $error("event did not set its status bit");
endmodule : usbei_irq_stat

// *** rtl/usbei_top.sv ***
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
// Function
// RULE1: Bits above the endpoint bits of the reset, enable and flag registers read as zero.
// RULE2: Firmware pulses an endpoint's FIFO clear bit before using that FIFO after any reset.
// RULE3: Each endpoint has an interrupt enable bit; one enables, zero disables.
// RULE4: An endpoint flag is set whenever any of its five interrupt sources is set.
// RULE5: The USB interrupt for an endpoint is raised only while enabled and flagged.
// RULE6: An endpoint flag clears by itself once all of its sources are clear.
// RULE7: The flag register is read-only, ignores writes and reads zero after reset.
// RULE8: A valid setup packet sets the setup source and clears the other status bits.
// RULE9: The IN-done source is set once an IN packet is sent or acknowledged.
// RULE10: The enabled endpoint conditions are ORed into one USB interrupt line.
module usbei_top #(
    parameter int num_ep = usbei_pkg::EP_NUM
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usbei_pkg::AW-1:0] paddr,
    input wire logic [usbei_pkg::DW-1:0] pwdata,
    output logic [usbei_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [num_ep-1:0] ev_in_done,
    input wire logic [num_ep-1:0] ev_out_bank0,
    input wire logic [num_ep-1:0] ev_out_bank1,
    input wire logic [num_ep-1:0] ev_setup,
    input wire logic [num_ep-1:0] ev_stall_crc,
    output logic [num_ep-1:0] fifo_clear,
    output logic usb_irq,
    output logic cpu_irq
);
    import usbei_pkg::*;

    localparam logic [RW-1:0] EP_MASK = RW'((1 << num_ep) - 1);

    // Endpoint bits must fit below the register width
    if (num_ep < 1 || num_ep > RW) begin : g_bad_num_ep
        $error("num_ep out of range");
    end

    logic [RW-1:0] irq_en_q, irq_en_d;
    logic [RW-1:0] fifo_rst_q, fifo_rst_d;
    logic [DW-1:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [num_ep-1:0] ep_flag_q, ep_flag_d;
    logic usb_irq_q, usb_irq_d;
    logic [num_ep-1:0] ep_flag;
    logic [num_ep-1:0] ep_rise;
    logic [num_ep-1:0] ev_stat;
    logic [num_ep-1:0] ev_mask;
    logic [num_ep-1:0] rd_clr;
    logic [num_ep-1:0] ep_clr;
    logic [RW-1:0] src_flags [num_ep];
    logic setup_ph;
    logic acc_wr;
    logic acc_rd;
    logic mask_we;

    // Bus phases; the slave never stretches the access phase
    assign setup_ph = psel && !penable;
    assign acc_wr = psel && penable && pwrite;
    assign acc_rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mask_we = acc_wr && paddr == reg_addr(IDX_EV_MASK);

    usbei_ep_if ep_if [num_ep] ();

    // One source-flag holder per endpoint
    for (genvar i = 0; i < num_ep; i++) begin : g_ep
        always_comb begin
            ep_if[i].set = '0;
            ep_if[i].set[SRC_IN_DONE] = ev_in_done[i]; // RULE9
            ep_if[i].set[SRC_OUT_B0] = ev_out_bank0[i];
            ep_if[i].set[SRC_OUT_B1] = ev_out_bank1[i];
            ep_if[i].set[SRC_SETUP] = ev_setup[i]; // RULE8
            ep_if[i].set[SRC_STALL_CRC] = ev_stall_crc[i];
        end
        assign ep_if[i].keep = pwdata[RW-1:0];
        assign ep_clr[i] = acc_wr && paddr == reg_addr(IDX_EP_STAT + IW'(i));
        assign ep_if[i].clr_stb = ep_clr[i];
        assign src_flags[i] = ep_if[i].flags;
        // Flag follows its sources, so it clears with the last of them
        assign ep_flag[i] = |ep_if[i].flags; // RULE4 RULE6

        usbei_ep_src u_src (
            .pclk(pclk),
            .presetn(presetn),
            .ep(ep_if[i])
        );
    end

    // A rising endpoint flag is the event for the status register
    assign ep_rise = ep_flag & ~ep_flag_q;

    // Clear only what the read returned, so a later event is not lost
    assign rd_clr = (acc_rd && paddr == reg_addr(IDX_EV_STAT)) ?
        prdata_q[num_ep-1:0] : '0;

    usbei_irq_stat #(
        .WIDTH(num_ep)
    ) u_stat (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ep_rise),
        .rd_clr(rd_clr),
        .mask_we(mask_we),
        .mask_wdata(pwdata[num_ep-1:0]),
        .stat(ev_stat),
        .mask(ev_mask),
        .irq(cpu_irq)
    );

    // Writable registers; reserved bits never store
    always_comb begin
        irq_en_d = irq_en_q;
        fifo_rst_d = fifo_rst_q;
        if (acc_wr && paddr == reg_addr(IDX_IRQ_EN)) begin
            irq_en_d = pwdata[RW-1:0] & EP_MASK; // RULE1 RULE3
        end
        if (acc_wr && paddr == reg_addr(IDX_FIFO_RST)) begin
            fifo_rst_d = pwdata[RW-1:0] & EP_MASK; // RULE1 RULE2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= IRQ_EN_RST;
            fifo_rst_q <= FIFO_RST_RST;
        end else begin
            irq_en_q <= irq_en_d;
            fifo_rst_q <= fifo_rst_d;
        end
    end

    // Read data is fetched in the setup cycle so it leaves a flip-flop
    always_comb begin
        logic [RW-1:0] rd_val;
        logic hit;
        rd_val = '0;
        hit = 1'b1;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup_ph) begin
            if (paddr == reg_addr(IDX_IRQ_EN)) begin
                rd_val = irq_en_q; // RULE1
            end else if (paddr == reg_addr(IDX_FIFO_RST)) begin
                rd_val = fifo_rst_q;
            end else if (paddr == reg_addr(IDX_IRQ_FLAGS)) begin
                rd_val[num_ep-1:0] = ep_flag; // RULE1 RULE7
            end else if (paddr == reg_addr(IDX_EV_STAT)) begin
                rd_val[num_ep-1:0] = ev_stat;
            end else if (paddr == reg_addr(IDX_EV_MASK)) begin
                rd_val[num_ep-1:0] = ev_mask;
            end else begin
                hit = 1'b0;
                for (int j = 0; j < num_ep; j++) begin
                    if (paddr == reg_addr(IDX_EP_STAT + IW'(j))) begin
                        rd_val = src_flags[j];
                        hit = 1'b1;
                    end
                end
            end
            prdata_d = {{(DW-RW){1'b0}}, rd_val};
            pslverr_d = !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Interrupt request gated per endpoint, then ORed; registered for a clean level
    always_comb begin
        ep_flag_d = ep_flag;
        usb_irq_d = |(ep_flag & irq_en_q[num_ep-1:0]); // RULE5 RULE10
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep_flag_q <= '0;
            usb_irq_q <= 1'b0;
        end else begin
            ep_flag_q <= ep_flag_d;
            usb_irq_q <= usb_irq_d;
        end
    end

    // Level outputs; the FIFO clear follows firmware's pulse of the bit
    assign fifo_clear = fifo_rst_q[num_ep-1:0]; // RULE2
    assign usb_irq = usb_irq_q;
    assign prdata = pslverr_q ? '0 : prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // Checks on the register front end and the interrupt path
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic any_clr;
    assign any_clr = |ep_clr;

    // Any source event per endpoint, as the host side reports it
    logic [num_ep-1:0] any_src;
    assign any_src = ev_in_done | ev_out_bank0 | ev_out_bank1 | ev_setup | ev_stall_crc;

    // Decoded apart from the read path, so a slip there shows up in the checks
    function automatic logic addr_mapped(input logic [AW-1:0] addr);
        logic hit;
        hit = addr == reg_addr(IDX_IRQ_EN) || addr == reg_addr(IDX_FIFO_RST)
            || addr == reg_addr(IDX_IRQ_FLAGS) || addr == reg_addr(IDX_EV_STAT)
            || addr == reg_addr(IDX_EV_MASK);
        for (int j = 0; j < num_ep; j++) begin
            hit = hit || addr == reg_addr(IDX_EP_STAT + IW'(j));
        end
        return hit;
    endfunction : addr_mapped

    rsv_reads_zero_a: assert property ( // RULE1
        setup_ph && (paddr == reg_addr(IDX_IRQ_EN) || paddr == reg_addr(IDX_FIFO_RST)
        || paddr == reg_addr(IDX_IRQ_FLAGS)) |=> (prdata[RW-1:0] & ~EP_MASK) == '0)
        else $error("reserved bits read nonzero");

    fifo_clear_out_a: assert property ( // RULE2
        acc_wr && paddr == reg_addr(IDX_FIFO_RST) |=>
        fifo_clear == $past(pwdata[num_ep-1:0]))
        else $error("fifo clear does not follow write");

    irq_en_write_a: assert property ( // RULE3
        acc_wr && paddr == reg_addr(IDX_IRQ_EN) |=>
        irq_en_q == ($past(pwdata[RW-1:0]) & EP_MASK))
        else $error("enable register not updated");

    flag_on_source_a: assert property ( // RULE4
        (|ev_out_bank0) |=> ((ep_flag & $past(ev_out_bank0)) == $past(ev_out_bank0)))
        else $error("endpoint flag missed its source");

    irq_needs_enable_a: assert property ( // RULE5
        usb_irq |-> $past(|(ep_flag & irq_en_q[num_ep-1:0])))
        else $error("usb irq without enabled flag");

    flag_auto_clear_a: assert property ( // RULE6
        (|(~ep_flag & ep_flag_q)) |-> $past(any_clr))
        else $error("endpoint flag fell without a source clear");

    flags_read_only_a: assert property ( // RULE7
        acc_wr && paddr == reg_addr(IDX_IRQ_FLAGS) && !any_clr |=>
        ($past(ep_flag) & ~ep_flag) == '0)
        else $error("flag register changed on write");

    irq_or_two_a: assert property ( // RULE10
        (|(ep_flag & irq_en_q[num_ep-1:0])) |=> usb_irq ##0 $past(ep_flag, 1) != '0)
        else $error("enabled flag did not raise usb irq");

    unmapped_zero_a: assert property (
        setup_ph && !addr_mapped(paddr) |=> !penable || (pslverr && prdata == '0))
        else $error("unmapped access not flagged");

    // Enable and fifo clear registers move only on their own writes
    en_holds_a: assert property ( // RULE3
        !(acc_wr && paddr == reg_addr(IDX_IRQ_EN)) |=> $stable(irq_en_q))
        else $error("enable register changed without a write");

    fifo_clr_holds_a: assert property ( // RULE2
        !(acc_wr && paddr == reg_addr(IDX_FIFO_RST)) |=> $stable(fifo_clear))
        else $error("fifo clear changed without a write");

    irq_off_disabled_a: assert property ( // RULE3
        irq_en_q[num_ep-1:0] == '0 |=> !usb_irq)
        else $error("usb irq with all endpoints disabled");

    irq_drops_a: assert property ( // RULE5
        !(|(ep_flag & irq_en_q[num_ep-1:0])) |=> !usb_irq)
        else $error("usb irq stayed high without enabled flag");

    flag_any_src_a: assert property ( // RULE4
        (|any_src) |=> (ep_flag & $past(any_src)) == $past(any_src))
        else $error("endpoint flag missed a source event");

    rise_needs_src_a: assert property ( // RULE4
        (ep_rise & ~$past(any_src)) == '0)
        else $error("endpoint flag rose without a source event");

    mask_write_a: assert property (
        mask_we |=> ev_mask == $past(pwdata[num_ep-1:0]))
        else $error("event mask not updated");

    stat_read_clear_a: assert property (
        acc_rd && paddr == reg_addr(IDX_EV_STAT) && ep_rise == '0 |=>
        (ev_stat & $past(prdata_q[num_ep-1:0])) == '0)
        else $error("event status not cleared by its read");

    cpu_irq_level_a: assert property (
        cpu_irq == |(ev_stat & ev_mask))
        else $error("cpu irq does not match masked status");

    // Main scenarios worth seeing at least once
    setup_irq_c: cover property (ev_setup[0] && irq_en_q[0] ##[1:3] usb_irq);
    stat_read_c: cover property (acc_rd && paddr == reg_addr(IDX_EV_STAT) && rd_clr != '0);
    unmapped_c: cover property (pslverr);
    fifo_pulse_c: cover property (fifo_clear[0] ##[1:20] !fifo_clear[0]);
    flag_write_c: cover property (acc_wr && paddr == reg_addr(IDX_IRQ_FLAGS));
endmodule : usbei_top

// *** verif/usbei_usb_host.sv ***
`timescale 1ns/10ps
// USB host side: each transaction ends in one event pulse
module usbei_usb_host (
    input wire logic pclk,
    output logic [2:0] ev_in_done,
    output logic [2:0] ev_out_bank0,
    output logic [2:0] ev_out_bank1,
    output logic [2:0] ev_setup,
    output logic [2:0] ev_stall_crc
);
    logic [14:0] ev_q = '0;
    // Kinds: in done, bank 0, bank 1, setup, stall or crc
    assign {ev_stall_crc, ev_setup, ev_out_bank1, ev_out_bank0, ev_in_done} = ev_q;
    // Gap models a slow host; waiting first keeps one assignment per edge
    task automatic send(input int kind, input int ep, input int gap);
        repeat (gap) @(posedge pclk);
        ev_q[kind*3+ep] <= 1'b1;
        @(posedge pclk);
        ev_q <= '0;
    endtask : send
endmodule : usbei_usb_host

// *** verif/tb_usb_endpoint_irq_fifo_reset.sv ***
`timescale 1ns/10ps
// Endpoint flag, enable and fifo clear test
module tb_usb_endpoint_irq_fifo_reset;
    import usbei_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [DW-1:0] pwdata = '0;
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ev_in_done;
    logic [2:0] ev_out_bank0;
    logic [2:0] ev_out_bank1;
    logic [2:0] ev_setup;
    logic [2:0] ev_stall_crc;
    logic [2:0] fifo_clear;
    logic usb_irq;
    logic cpu_irq;
    logic [31:0] rd;
    logic err;
    logic [7:0] en;
    logic [7:0] msk;
    int errors = 0;
    int compares = 0;

    always #50 pclk = ~pclk;

    usbei_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ev_in_done(ev_in_done),
        .ev_out_bank0(ev_out_bank0), .ev_out_bank1(ev_out_bank1),
        .ev_setup(ev_setup), .ev_stall_crc(ev_stall_crc),
        .fifo_clear(fifo_clear), .usb_irq(usb_irq), .cpu_irq(cpu_irq));

    usbei_usb_host host (.pclk(pclk), .ev_in_done(ev_in_done),
        .ev_out_bank0(ev_out_bank0), .ev_out_bank1(ev_out_bank1),
        .ev_setup(ev_setup), .ev_stall_crc(ev_stall_crc));

    // Count every compare, report each mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [IW-1:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read a register and compare the whole word
    task automatic rdc(input logic [IW-1:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h00_0000, exp});
    endtask : rdc

    // Status bit each host transaction should light
    function automatic logic [7:0] src_bit(input int k);
        case (k)
            0: return 8'h01 << SRC_IN_DONE;
            1: return 8'h01 << SRC_OUT_B0;
            2: return 8'h01 << SRC_OUT_B1;
            3: return 8'h01 << SRC_SETUP;
            default: return 8'h01 << SRC_STALL_CRC;
        endcase
    endfunction : src_bit

    task automatic stop_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Run needs well under a thousand cycles; this catches a hang
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h979d_271f));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rdc(IDX_IRQ_EN, IRQ_EN_RST);
        rdc(IDX_FIFO_RST, FIFO_RST_RST);
        rdc(IDX_IRQ_FLAGS, 8'h00);
        check(32'(usb_irq), 32'h0);
        $display("test reset done");
        // Fifo clear pulse on all endpoints; firmware never sets reserved bits
        apb(1'b1, IDX_FIFO_RST, 8'h07);
        @(negedge pclk);
        check(32'(fifo_clear), 32'h7);
        rdc(IDX_FIFO_RST, 8'h07);
        apb(1'b1, IDX_FIFO_RST, 8'h00);
        @(negedge pclk);
        check(32'(fifo_clear), 32'h0);
        apb(1'b1, IDX_IRQ_EN, 8'h05);
        rdc(IDX_IRQ_EN, 8'h05);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h07);
        rdc(IDX_IRQ_FLAGS, 8'h00);
        apb(1'b0, 10'h0FF, 8'h00);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("test registers done");
        // Every source kind on every endpoint, random enables and mask
        for (int k = 0; k < 5; k++) begin
            for (int e = 0; e < 3; e++) begin
                en = 8'($urandom_range(0, 7));
                msk = 8'($urandom_range(0, 7));
                apb(1'b1, IDX_IRQ_EN, en);
                apb(1'b1, IDX_EV_MASK, msk);
                host.send(k, e, $urandom_range(1, 4));
                repeat (3) @(posedge pclk);
                @(negedge pclk);
                check(32'(usb_irq), 32'(en[e]));
                check(32'(cpu_irq), 32'(msk[e]));
                rdc(IDX_IRQ_FLAGS, 8'h01 << e);
                rdc(IW'(IDX_EP_STAT + e), src_bit(k));
                rdc(IDX_EV_STAT, 8'h01 << e);
                rdc(IDX_EV_STAT, 8'h00);
                apb(1'b1, IW'(IDX_EP_STAT + e), 8'h00);
                repeat (3) @(posedge pclk);
                @(negedge pclk);
                check(32'(usb_irq), 32'h0);
                rdc(IDX_IRQ_FLAGS, 8'h00);
            end
        end
        rdc(IDX_IRQ_EN, en);
        rdc(IDX_EV_MASK, msk);
        $display("test sources done");
        // Setup wipes earlier sources of the same endpoint
        host.send(0, 1, 1);
        host.send(4, 1, 1);
        host.send(3, 1, 2);
        repeat (2) @(posedge pclk);
        rdc(IW'(IDX_EP_STAT + 1), SRC_SETUP_ONLY);
        rdc(IDX_IRQ_FLAGS, 8'h02);
        $display("test setup done");
        stop_test();
    end
endmodule : tb_usb_endpoint_irq_fifo_reset
